//--- hdl/iah_pkg.sv
// Constants and types shared by the acknowledge and halt controller
package iah_pkg;

  localparam int          NUM_SRC   = 8;
  localparam int          SRC_IDX_W = 3;
  localparam int          ACK_CNT_W = 3;
  localparam int          WDT_CNT_W = 3;

  // Acknowledge sequence, counted from its first clock
  localparam int          ACK_CLKS         = 8;
  localparam logic [2:0]  ACK_PUSH_STATUS  = 3'h2;
  localparam logic [2:0]  ACK_PUSH_COUNTER = 3'h4;
  localparam logic [2:0]  ACK_LOAD_VECTOR  = 3'(ACK_CLKS - 1);

  // Wake-up waits after a halt release, in CPU clocks
  localparam int          WAKE_VEC_CLKS    = 1 + ACK_CLKS;
  localparam int          WAKE_CONT_CLKS   = 2;

  // Internal watchdog reset is stretched to this many clocks
  localparam logic [2:0]  WDT_RST_CLKS     = 3'h4;

  localparam logic [NUM_SRC-1:0] FLAGS_RST = 8'h00;
  localparam logic [2:0]         IDX_RST   = 3'h0;

  typedef enum logic [2:0] {
    IAH_IDLE,
    IAH_HALT,
    IAH_WAKE,
    IAH_ACK,
    IAH_RESET
  } iah_state_e;

endpackage

//--- hdl/iah_sync.sv
// Two-flop synchroniser for a level arriving from outside the clock domain
`timescale 1ns/1ps
module iah_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta     <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

//--- hdl/iah_ctrl.sv
// Interrupt acknowledge sequencing and halt standby control
`timescale 1ns/1ps
module iah_ctrl (
  input  wire logic                           mclk,
  input  wire logic                           arst_n,
  input  wire logic                           instr_last,
  input  wire logic                           instr_halt,
  input  wire logic                           instr_irq_access,
  input  wire logic                           enable_irq_instruction,
  input  wire logic                           disable_irq_instruction,
  input  wire logic [iah_pkg::NUM_SRC-1:0]    src_event,
  input  wire logic [iah_pkg::NUM_SRC-1:0]    flag_sw_set,
  input  wire logic [iah_pkg::NUM_SRC-1:0]    flag_sw_clr,
  input  wire logic [iah_pkg::NUM_SRC-1:0]    request_mask_bit,
  input  wire logic                           nmi_event,
  input  wire logic                           main_clock_stop_control,
  input  wire logic                           ext_reset_pin_n,
  input  wire logic                           wdt_overflow,
  output logic [iah_pkg::NUM_SRC-1:0]         request_pending_flag,
  output logic                                global_irq_enable_flag,
  output logic                                seq_stall,
  output logic                                cpu_clk_en,
  output logic                                halt_active,
  output logic                                ack_start,
  output logic                                ack_push_status,
  output logic                                ack_push_counter,
  output logic                                ack_load_vector,
  output logic                                ack_is_nmi,
  output logic [iah_pkg::SRC_IDX_W-1:0]       ack_src_idx,
  output logic                                quadrupled_subclock_en,
  output logic                                timer0_external_count_en,
  output logic                                cpu_reset,
  output logic                                reset_vector_load
);
  import iah_pkg::*;

  // Lowest index wins among maskable sources
  function automatic logic [NUM_SRC-1:0] prio_pick(input logic [NUM_SRC-1:0] req);
    logic [NUM_SRC-1:0] pick;
    pick = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        pick = '0;
        pick[i] = 1'b1;
      end
    end
    return pick;
  endfunction

  function automatic logic [SRC_IDX_W-1:0] onehot_idx(input logic [NUM_SRC-1:0] oh);
    logic [SRC_IDX_W-1:0] idx;
    idx = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (oh[i]) begin
        idx = SRC_IDX_W'(i);
      end
    end
    return idx;
  endfunction

  iah_state_e           state;
  iah_state_e           next_state;
  logic [ACK_CNT_W-1:0] ack_cnt;
  logic [NUM_SRC-1:0]   flags;
  logic                 nmi_pend;
  logic                 enable_flag;
  logic                 ext_reset_n_sync;
  logic [WDT_CNT_W-1:0] wdt_rst_cnt;
  logic                 sys_reset;
  logic                 sys_reset_q;

  wire [NUM_SRC-1:0] eligible;
  wire               any_eligible;
  wire               take_ok;
  wire               halt_release;
  wire               at_boundary;
  wire [NUM_SRC-1:0] take_sel;
  wire [NUM_SRC-1:0] ack_clr;
  wire [NUM_SRC-1:0] next_flags;
  wire               next_nmi_pend;
  wire               next_enable_flag;

  iah_sync #(
    .RST_VAL (1'b0)
  ) u_reset_sync (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .async_in (ext_reset_pin_n),
    .sync_out (ext_reset_n_sync)
  );

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_rst_cnt <= '0;
    end else if (wdt_overflow) begin
      wdt_rst_cnt <= WDT_RST_CLKS;
    end else if (wdt_rst_cnt != '0) begin
      wdt_rst_cnt <= wdt_rst_cnt - 1'b1;
    end
  end

  assign sys_reset = !ext_reset_n_sync || (wdt_rst_cnt != '0);

  assign eligible     = flags & ~request_mask_bit;
  assign any_eligible = |eligible;
  assign take_ok      = nmi_pend || (enable_flag && any_eligible);
  // release on unmasked or non-maskable request
  assign halt_release = nmi_pend || any_eligible;
  // boundary uses flags registered before the last clock
  assign at_boundary  = (state == IAH_IDLE) && instr_last && !instr_irq_access;
  assign take_sel     = nmi_pend ? '0 : prio_pick(eligible);

  assign ack_start = !sys_reset && take_ok && (at_boundary || state == IAH_WAKE);

  always_comb begin
    next_state = state;
    if (sys_reset) begin
      next_state = IAH_RESET;
    end else begin
      unique case (state)
        IAH_RESET: next_state = IAH_IDLE;
        IAH_IDLE: begin
          if (at_boundary && take_ok) begin
            next_state = IAH_ACK;
          // halt only once the instruction completes, no pending release
          end else if (at_boundary && instr_halt && !halt_release) begin
            next_state = IAH_HALT;
          end
        end
        // masked requests leave halt in force
        IAH_HALT: next_state = halt_release ? IAH_WAKE : IAH_HALT;
        // one wake clock, then vectored or continue
        IAH_WAKE: next_state = take_ok ? IAH_ACK : IAH_IDLE;
        IAH_ACK:  next_state = (ack_cnt == ACK_LOAD_VECTOR) ? IAH_IDLE : IAH_ACK;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state   <= IAH_RESET;
      ack_cnt <= '0;
    end else begin
      state   <= next_state;
      ack_cnt <= (state == IAH_ACK) ? ack_cnt + 1'b1 : '0;
    end
  end

  // flag cleared on acknowledge, a new event still wins
  assign ack_clr    = ack_start ? take_sel : '0;
  assign next_flags = sys_reset ? FLAGS_RST
                    : ((flags & ~flag_sw_clr & ~ack_clr) | src_event | flag_sw_set);
  assign next_nmi_pend = !sys_reset && ((nmi_pend && !(ack_start && nmi_pend)) || nmi_event);

  // enable set only by instruction, cleared by ack
  assign next_enable_flag = sys_reset ? 1'b0
                          : ack_start ? 1'b0
                          : (state == IAH_IDLE && enable_irq_instruction) ? 1'b1
                          : (state == IAH_IDLE && disable_irq_instruction) ? 1'b0
                          : enable_flag;

  // enable holds while halted; flags still take new events and clears
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flags       <= FLAGS_RST;
      nmi_pend    <= 1'b0;
      enable_flag <= 1'b0;
    end else begin
      flags       <= next_flags;
      nmi_pend    <= next_nmi_pend;
      enable_flag <= next_enable_flag;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ack_is_nmi  <= 1'b0;
      ack_src_idx <= IDX_RST;
      sys_reset_q <= 1'b1;
    end else begin
      sys_reset_q <= sys_reset;
      if (ack_start) begin
        ack_is_nmi  <= nmi_pend;
        ack_src_idx <= onehot_idx(take_sel);
      end
    end
  end

  // status push, counter push, then vector load
  assign ack_push_status  = (state == IAH_ACK) && (ack_cnt == ACK_PUSH_STATUS);
  assign ack_push_counter = (state == IAH_ACK) && (ack_cnt == ACK_PUSH_COUNTER);
  assign ack_load_vector  = (state == IAH_ACK) && (ack_cnt == ACK_LOAD_VECTOR);

  assign request_pending_flag   = flags;
  assign global_irq_enable_flag = enable_flag;
  assign seq_stall              = state != IAH_IDLE;
  // CPU clock gated in halt and wake
  assign cpu_clk_en             = (state != IAH_HALT) && (state != IAH_WAKE);
  assign halt_active            = state == IAH_HALT;
  assign quadrupled_subclock_en = state != IAH_HALT;
  // pin counting in halt only with main clock running
  assign timer0_external_count_en = (state != IAH_HALT) || !main_clock_stop_control;
  // reset leaves halt and fetches reset vector
  assign cpu_reset         = sys_reset;
  assign reset_vector_load = sys_reset_q && !sys_reset;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  boundary_take_a: assert property (
    (at_boundary && take_ok && !sys_reset) |=> (state == IAH_ACK) && (ack_cnt == '0))
    else $error("eligible request not taken at instruction end");

  late_flag_a: assert property (
    (at_boundary && !take_ok && !instr_halt && !sys_reset) |=> state == IAH_IDLE)
    else $error("acknowledge began without a prior flag");

  access_hold_a: assert property (
    (state == IAH_IDLE && instr_last && instr_irq_access) |=> state != IAH_ACK)
    else $error("request taken during flag register access");

  no_nest_a: assert property (
    (state == IAH_IDLE && !enable_flag && !nmi_pend) |-> !ack_start)
    else $error("maskable request taken with enable clear");

  ack_length_a: assert property (
    (ack_start && !sys_reset) ##1 !sys_reset [*7] |=> ack_load_vector)
    else $error("vector load not eight clocks after ack start");

  ack_disables_a: assert property (
    ack_push_status |-> !enable_flag && $past(ack_push_status, 2) == 1'b0)
    else $error("enable flag set during acknowledge");

  flag_clear_a: assert property (
    (ack_start && !nmi_pend && (take_sel & (src_event | flag_sw_set)) == '0 && !sys_reset)
      |=> (flags & $past(take_sel)) == '0)
    else $error("acknowledged flag still set");

  halt_gate_a: assert property (
    (state == IAH_HALT) |-> !cpu_clk_en && !quadrupled_subclock_en)
    else $error("CPU clock running in halt");

  wake_vector_a: assert property (
    (state == IAH_HALT && nmi_pend && !sys_reset) ##1 !sys_reset [*8] |=> ack_load_vector)
    else $error("vectored wake not nine clocks");

  wake_cont_a: assert property (
    (state == IAH_HALT && any_eligible && !enable_flag && !nmi_pend && !sys_reset)
      ##1 (!sys_reset && !nmi_pend) |=> cpu_clk_en)
    else $error("continue wake not two clocks");

  masked_hold_a: assert property (
    (state == IAH_HALT && !halt_release && !sys_reset) |=> state == IAH_HALT)
    else $error("halt left without release");

  reset_halt_a: assert property (
    (state == IAH_HALT && sys_reset) |=> state == IAH_RESET ##1 (sys_reset || reset_vector_load))
    else $error("reset did not end halt");

  halt_blocked_a: assert property (
    (at_boundary && instr_halt && halt_release) |=> state != IAH_HALT)
    else $error("halt entered with release pending");

  nmi_wake_a: assert property (
    (state == IAH_WAKE && nmi_pend && !sys_reset) |-> ack_start)
    else $error("non-maskable wake not vectored");

endmodule

//--- testbench/iah_seq_model.sv
// Instruction sequencer model: fixed-length instructions, restarted from the first clock while stalled
`timescale 1ns/1ps
module iah_seq_model #(
  parameter int LEN = 4
) (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic seq_stall,
  input  wire logic halt_req,
  input  wire logic access_req,
  output logic      instr_last,
  output logic      instr_halt,
  output logic      instr_irq_access
);
  int cnt;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) cnt <= 0;
    else if (seq_stall) cnt <= 0;
    else cnt <= (cnt == LEN - 1) ? 0 : cnt + 1;
  end
  assign instr_last = !seq_stall && cnt == LEN - 1;
  assign instr_halt = instr_last && halt_req;
  assign instr_irq_access = instr_last && access_req;
endmodule

//--- testbench/tb.sv
// Self-checking bench for the acknowledge and halt controller
`timescale 1ns/1ps
module tb;
  import iah_pkg::*;
  logic       mclk, arst_n, halt_req, acc, en_ins, dis, nmi, clk_stop, pin_n, wdt;
  logic [7:0] ev, mask, flags, swc;
  logic       last, ihalt, iacc, ien, stall, clk_en, halt_active, ack_start, push_s, push_c, ack_load_vector;
  logic       is_nmi, quad, t0en, cpu_reset, reset_vector_load;
  logic [2:0] idx;
  int         failures, cmp_count;

  iah_seq_model seq (.mclk(mclk), .arst_n(arst_n), .seq_stall(stall), .halt_req(halt_req), .access_req(acc),
    .instr_last(last), .instr_halt(ihalt), .instr_irq_access(iacc));
  iah_ctrl dut (.mclk(mclk), .arst_n(arst_n), .instr_last(last), .instr_halt(ihalt), .instr_irq_access(iacc),
    .enable_irq_instruction(en_ins), .disable_irq_instruction(dis), .src_event(ev), .flag_sw_set(8'h00),
    .flag_sw_clr(swc), .request_mask_bit(mask), .nmi_event(nmi), .main_clock_stop_control(clk_stop),
    .ext_reset_pin_n(pin_n), .wdt_overflow(wdt), .request_pending_flag(flags), .global_irq_enable_flag(ien),
    .seq_stall(stall), .cpu_clk_en(clk_en), .halt_active(halt_active), .ack_start(ack_start),
    .ack_push_status(push_s), .ack_push_counter(push_c), .ack_load_vector(ack_load_vector),
    .ack_is_nmi(is_nmi), .ack_src_idx(idx), .quadrupled_subclock_en(quad),
    .timer0_external_count_en(t0en), .cpu_reset(cpu_reset), .reset_vector_load(reset_vector_load));

  initial begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end

  task automatic report_and_stop();
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  function automatic logic pick(int w);
    case (w)
      0: return ack_start;
      1: return ack_load_vector;
      2: return reset_vector_load;
      3: return halt_active;
      default: return clk_en;
    endcase
  endfunction
  task automatic wt(input int w, input int lim, output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (pick(w) !== 1'b1 && n < lim);
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic pev(logic [7:0] v);
    @(posedge mclk) ev <= v;
    @(posedge mclk) ev <= 8'h00;
  endtask
  task automatic pei();
    @(posedge mclk) en_ins <= 1'b1;
    @(posedge mclk) en_ins <= 1'b0;
  endtask
  task automatic ack_idx(logic [2:0] i, string m);
    int n;
    wt(0, 30, n);
    cyc(1);
    chk(idx === i && ien === 1'b0 && flags[i] === 1'b0, m);
    cyc(7);
  endtask
  task automatic enter_halt();
    int n;
    @(posedge mclk) halt_req <= 1'b1;
    wt(3, 30, n);
    @(posedge mclk) halt_req <= 1'b0;
  endtask

  task automatic t_ack();
    int n;
    pei();
    cyc(1);
    chk(ien === 1'b1, "enable flag not set");
    pev(8'h08);
    wt(0, 30, n);
    cyc(1);
    chk(idx === 3'h3 && flags[3] === 1'b0 && ien === 1'b0 && stall === 1'b1, "ack state wrong");
    cyc(2);
    chk(push_s === 1'b1, "status push late");
    cyc(2);
    chk(push_c === 1'b1, "counter push late");
    cyc(3);
    chk(ack_load_vector === 1'b1 && n + 8 >= 9 && n + 8 <= 19, "service start delay");
  endtask
  task automatic t_prio();
    int n;
    pei();
    pev(8'h24);
    ack_idx(3'h2, "priority order");
    wt(0, 24, n);
    chk(pick(0) !== 1'b1 && flags[5] === 1'b1, "nested without enable");
    pei();
    ack_idx(3'h5, "pending not served");
  endtask
  task automatic t_hold();
    int n;
    pei();
    @(posedge mclk) acc <= 1'b1;
    pev(8'h02);
    wt(0, 20, n);
    chk(pick(0) !== 1'b1, "taken during access");
    @(posedge mclk) acc <= 1'b0;
    ack_idx(3'h1, "held request lost");
  endtask
  task automatic t_halt();
    int n;
    @(posedge mclk) mask <= 8'h10;
    enter_halt();
    cyc(1);
    chk(clk_en === 1'b0 && quad === 1'b0 && t0en === 1'b1, "halt outputs");
    @(posedge mclk) clk_stop <= 1'b1;
    cyc(1);
    chk(t0en === 1'b0 && halt_active === 1'b1, "timer pin with clock stopped");
    @(posedge mclk) clk_stop <= 1'b0;
    pev(8'h10);
    cyc(10);
    chk(halt_active === 1'b1 && flags[4] === 1'b1, "masked request released");
    @(posedge mclk) mask <= 8'h00;
    wt(4, 6, n);
    chk(n <= 3 && halt_active === 1'b0 && flags[4] === 1'b1, "continue release");
    @(posedge mclk) halt_req <= 1'b1;
    wt(3, 12, n);
    chk(n == 12 && halt_active === 1'b0, "halt with pending release");
    @(posedge mclk) halt_req <= 1'b0;
    pei();
    ack_idx(3'h4, "released request not served");
  endtask
  task automatic t_nmi();
    int n;
    enter_halt();
    @(posedge mclk) nmi <= 1'b1;
    @(posedge mclk) nmi <= 1'b0;
    wt(1, 15, n);
    chk(ack_load_vector === 1'b1 && is_nmi === 1'b1 && n >= 9 && n <= 11, "nmi wake");
  endtask
  task automatic t_rst();
    int n;
    cyc(2);
    enter_halt();
    @(posedge mclk) pin_n <= 1'b0;
    cyc(4);
    chk(halt_active === 1'b0 && cpu_reset === 1'b1, "pin reset in halt");
    @(posedge mclk) pin_n <= 1'b1;
    wt(2, 10, n);
    chk(reset_vector_load === 1'b1, "no vector fetch");
    @(posedge mclk) mask <= 8'h80;
    pev(8'h80);
    cyc(1);
    chk(flags === 8'h80, "masked flag not set");
    @(posedge mclk) wdt <= 1'b1;
    @(posedge mclk) wdt <= 1'b0;
    cyc(2);
    chk(cpu_reset === 1'b1 && flags === 8'h00, "watchdog reset");
    wt(2, 12, n);
    chk(reset_vector_load === 1'b1, "no vector after watchdog");
  endtask
  task automatic t_dis();
    pei();
    cyc(1);
    chk(ien === 1'b1, "enable flag not set again");
    @(posedge mclk) dis <= 1'b1;
    @(posedge mclk) dis <= 1'b0;
    cyc(1);
    chk(ien === 1'b0 && pick(0) !== 1'b1, "disable instruction ignored");
    @(posedge mclk) ev <= 8'h40;
    swc <= 8'h40;
    @(posedge mclk) ev <= 8'h00;
    swc <= 8'h00;
    cyc(1);
    chk(flags[6] === 1'b1, "clear beat a new request");
    @(posedge mclk) swc <= 8'h40;
    @(posedge mclk) swc <= 8'h00;
    cyc(1);
    chk(flags[6] === 1'b0, "software clear lost");
  endtask

  initial begin
    arst_n = 0; halt_req = 0; acc = 0; en_ins = 0; dis = 0; nmi = 0; clk_stop = 0; pin_n = 1; wdt = 0;
    ev = 8'h00; mask = 8'h00; swc = 8'h00; failures = 0; cmp_count = 0;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    cyc(8);
    t_ack();
    t_prio();
    t_hold();
    t_halt();
    t_nmi();
    t_rst();
    t_dis();
    report_and_stop();
  end
  initial begin
    repeat (3000) @(posedge mclk);
    failures++;
    report_and_stop();
  end
endmodule
